/* File: pkg/mfsm_defines.svh */
// constants for the fault and stall monitor
`ifndef MFSM_DEFINES_SVH
`define MFSM_DEFINES_SVH
`define MFSM_CLK_MHZ        40
`define MFSM_TALLY_W        12
`define MFSM_ZERO12         12'h000
`define MFSM_SCALE_LIMIT    12'h1f4
`define MFSM_SCALE_SHIFT    3
`define MFSM_AVG_SHIFT      2
`define MFSM_AVG_DEPTH      4
`define MFSM_OCP_FILT_NS    2000
`define MFSM_OCP_FILT_CYC   ((`MFSM_OCP_FILT_NS * `MFSM_CLK_MHZ) / 1000)
`define MFSM_RETRY_US       4000
`define MFSM_RETRY_CYC      ((`MFSM_RETRY_US * `MFSM_CLK_MHZ))
`define MFSM_CNT_W          20
`define MFSM_SHORTS_W       8
`define MFSM_LEARN_MARGIN   12'h010
`endif

/* File: pkg/mfsm_pkg.sv */
// types for the fault and stall monitor
package mfsm_pkg;
    typedef enum logic [1:0] {
        MFSM_OC_IDLE  = 2'b00,
        MFSM_OC_TRIP  = 2'b01,
        MFSM_OC_RETRY = 2'b10
    } mfsm_oc_e;

    typedef enum logic [1:0] {
        MFSM_LRN_IDLE = 2'b00,
        MFSM_LRN_RUN  = 2'b01,
        MFSM_LRN_DONE = 2'b10
    } mfsm_lrn_e;

    typedef struct packed {
        logic fault;
        logic supply_low_flag;
        logic pump_undervolt_flag;
        logic overcurrent_flag;
        logic blocked_flag;
        logic blocked_detail_flag;
        logic threshold_learn_done;
    } mfsm_flags_s;
endpackage : mfsm_pkg

/* File: tb/mfsm_host_model.sv */
// controller model that issues clear commands and sleep reset pulses
`timescale 1ns/10ps
`default_nettype none
module mfsm_host_model (
    // clock
    input  wire logic sys_clk,
    // requests from the bench
    input  wire logic clear_req,
    input  wire logic sleep_req,
    // pins toward the monitor
    output var logic  clear_faults_cmd,
    output var logic  sleep_pin_n
);
    logic [2:0] sleep_cnt;
    initial begin
        clear_faults_cmd = 1'b0;
        sleep_pin_n = 1'b1;
        sleep_cnt = 3'h0;
    end
    // a one-cycle request gives a one-cycle command pulse
    always @(posedge sys_clk) begin
        clear_faults_cmd <= clear_req;
        if (sleep_req) begin
            sleep_cnt <= 3'h6;
        end else if (sleep_cnt != 3'h0) begin
            sleep_cnt <= sleep_cnt - 3'h1;
        end
        // low long enough to pass the 2-ff sync, then a rising edge
        sleep_pin_n <= (sleep_cnt == 3'h0) && !sleep_req;
    end
endmodule : mfsm_host_model
`default_nettype wire

/* File: tb/mfsm_monitor_props.sv */
// port assertions for the fault and stall monitor
`timescale 1ns/10ps
`default_nettype none
module mfsm_monitor_props
    import mfsm_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // watched inputs
    input  wire logic        clear_faults_cmd,
    input  wire logic        sleep_pin_n,
    input  wire logic        ripple_mode,
    input  wire logic        blocked_detect_enable,
    input  wire logic        blocked_pin_report,
    input  wire logic        half_cycle_done,
    // watched outputs
    input  wire mfsm_flags_s flags,
    input  wire logic [7:0]  tally_low_reg,
    input  wire logic [3:0]  tally_high_reg,
    input  wire logic [1:0]  bridge_enable,
    input  wire logic        pump_enable,
    input  wire logic        error_pin_n_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // sleep history covers the sync delay of a pending reset pulse
    logic [3:0] sleep_hist;
    wire        quiet = (&sleep_hist) && sleep_pin_n && !clear_faults_cmd;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sleep_hist <= 4'h0;
        end else begin
            sleep_hist <= {sleep_hist[2:0], sleep_pin_n};
        end
    end
    a_pin_needs_fault: assert property (
        !error_pin_n_oe |-> flags.fault)
        else $error("fault pin low without fault flag");
    a_oc_trip_off: assert property (
        $rose(flags.overcurrent_flag) |->
        ##[0:1] (bridge_enable != 2'b11 && !error_pin_n_oe))
        else $error("overcurrent trip left bridge on");
    a_supply_low_off: assert property (
        $rose(flags.supply_low_flag) |->
        bridge_enable == 2'b00 && !pump_enable)
        else $error("supply low did not stop outputs");
    a_pump_low_run: assert property (
        $rose(flags.pump_undervolt_flag) |->
        bridge_enable == 2'b00 && pump_enable && !error_pin_n_oe)
        else $error("pump undervoltage handling wrong");
    a_tally_hold: assert property (
        !$past(half_cycle_done) |->
        $stable({tally_high_reg, tally_low_reg}))
        else $error("tally changed between updates");
    a_stall_gate: assert property (
        $rose(flags.blocked_flag) |->
        $past(ripple_mode) && $past(blocked_detect_enable))
        else $error("stall flagged while detection off");
    a_stall_silent: assert property (
        $rose(flags.blocked_flag) && !blocked_pin_report &&
        error_pin_n_oe |=> error_pin_n_oe [*3])
        else $error("stall drove pin without report bit");
    a_stall_holds: assert property (
        flags.blocked_flag && quiet |=> flags.blocked_flag)
        else $error("stall flag dropped without clear");
    a_pump_holds: assert property (
        flags.pump_undervolt_flag && quiet |=> flags.pump_undervolt_flag)
        else $error("pump flag dropped without clear");
    cover property ($rose(flags.blocked_flag));
    cover property ($fell(flags.overcurrent_flag));
    cover property ($rose(flags.threshold_learn_done));
endmodule : mfsm_monitor_props
bind mfsm_monitor mfsm_monitor_props u_props (.sys_clk, .reset,
    .clear_faults_cmd, .sleep_pin_n, .ripple_mode, .blocked_detect_enable,
    .blocked_pin_report, .half_cycle_done, .flags, .tally_low_reg,
    .tally_high_reg, .bridge_enable, .pump_enable, .error_pin_n_oe);
`default_nettype wire

/* File: tb/mfsm_monitor_test.sv */
// self-checking bench for the fault and stall monitor
`timescale 1ns/10ps
`default_nettype none
module mfsm_monitor_test;
    import mfsm_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, supply_low_cmp = 1'b1;
    logic pump_low_cmp = 1'b0, ocsel = 1'b0, ripple = 1'b0, enable = 1'b0;
    logic report = 1'b0, scale = 1'b0, learn = 1'b0, th_wr = 1'b0, en = 1'b1;
    logic hcd = 1'b0, clear_req = 1'b0, sleep_req = 1'b0, clr, slp_n, pump;
    logic [3:0] limit = 4'h0;
    logic [7:0] shorts = 8'h00, diag, t_lo;
    logic [11:0] th_data = 12'h000, rise = 12'h000, fall = 12'h000, th;
    logic [3:0] t_hi;
    logic [1:0] br;
    logic oe, pin_out;
    mfsm_flags_s flags;
    int mismatches = 0, checks_done = 0;
    always #12.5 sys_clk = ~sys_clk;
    mfsm_host_model host (.sys_clk(sys_clk), .clear_req(clear_req),
        .sleep_req(sleep_req), .clear_faults_cmd(clr), .sleep_pin_n(slp_n));
    // short retry keeps the auto-recovery case brief
    mfsm_monitor #(.RETRY_CYC(20)) dut (.sys_clk(sys_clk), .reset(reset),
        .clk_en(en), .supply_low_cmp(supply_low_cmp),
        .pump_low_cmp(pump_low_cmp), .bridge_limit(limit),
        .short_sense(shorts), .sleep_pin_n(slp_n),
        .overcurrent_recovery_select(ocsel), .clear_faults_cmd(clr),
        .ripple_mode(ripple), .blocked_detect_enable(enable),
        .blocked_pin_report(report), .tally_scale_bit(scale),
        .threshold_learn_start(learn), .threshold_wr(th_wr),
        .threshold_wdata(th_data), .half_cycle_done(hcd),
        .off_time_rise(rise), .off_time_fall(fall), .flags(flags),
        .short_diag_reg(diag), .tally_low_reg(t_lo), .tally_high_reg(t_hi),
        .blocked_threshold(th), .bridge_enable(br), .pump_enable(pump),
        .error_pin_n_out(pin_out), .error_pin_n_oe(oe));
    // ==========================================================
    // shared helpers
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    // sel picks the request: 0 clear, 1 sleep pulse, 2 threshold write
    task automatic pulse(input int sel);
        @(posedge sys_clk);
        clear_req <= (sel == 0);
        sleep_req <= (sel == 1);
        th_wr     <= (sel == 2);
        @(posedge sys_clk);
        clear_req <= 1'b0;
        sleep_req <= 1'b0;
        th_wr     <= 1'b0;
        cyc(16);
    endtask : pulse
    // n half-cycles whose off-time difference is d
    task automatic hc(input logic [11:0] d, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            hcd <= 1'b1;
            rise <= d + 12'h100;
            fall <= 12'h100;
            @(posedge sys_clk) hcd <= 1'b0;
            cyc(2);
        end
    endtask : hc
    task automatic end_of_test;
        if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // scenarios
    task automatic t_supply;
        @(posedge sys_clk) supply_low_cmp <= 1'b1;
        cyc(5);
        chk(flags, 12'h060);
        chk({br, pump, oe}, 12'h0);
        @(posedge sys_clk) supply_low_cmp <= 1'b0;
        cyc(5);
        chk(flags, 12'h020);
        chk({br, pump, oe}, 12'hf);
        pulse(0);
        chk(flags, 12'h000);
    endtask : t_supply
    task automatic t_pump;
        @(posedge sys_clk) pump_low_cmp <= 1'b1;
        cyc(5);
        chk({flags.pump_undervolt_flag, br, pump, oe}, 12'h12);
        @(posedge sys_clk) pump_low_cmp <= 1'b0;
        cyc(5);
        chk({flags.pump_undervolt_flag, br, pump, oe}, 12'h1f);
        pulse(1);
        chk(flags, 12'h000);
    endtask : t_pump
    task automatic t_ocp;
        @(posedge sys_clk) limit <= 4'h1;
        shorts <= 8'h81;
        cyc(40);
        chk(flags.overcurrent_flag, 12'h0);
        cyc(60);
        chk({flags.overcurrent_flag, br, pump, oe}, 12'h1a);
        chk(diag, 12'h081);
        chk(pin_out, 12'h0);
        @(posedge sys_clk) limit <= 4'h0;
        shorts <= 8'h00;
        cyc(40);
        chk({br, oe, diag}, 12'h481);
        pulse(0);
        chk({flags.overcurrent_flag, br, oe, diag}, 12'h700);
        @(posedge sys_clk) ocsel <= 1'b1;
        limit <= 4'h4;
        cyc(100);
        chk(br, 12'h1);
        @(posedge sys_clk) limit <= 4'h0;
        cyc(30);
        chk({br, oe}, 12'h7);
        pulse(0);
    endtask : t_ocp
    task automatic t_tally;
        hc(12'h064, 4);
        chk({t_hi, t_lo}, 12'h064);
        hc(12'h1f4, 1);
        chk({t_hi, t_lo}, 12'h0c8);
        @(posedge sys_clk) scale <= 1'b1;
        hc(12'h064, 4);
        chk({t_hi, t_lo}, 12'h320);
        hc(12'h258, 4);
        chk({t_hi, t_lo}, 12'h258);
        @(posedge sys_clk) scale <= 1'b0;
        // enable low: a half-cycle must leave the tally untouched
        en <= 1'b0;
        hc(12'h200, 1);
        chk({t_hi, t_lo}, 12'h258);
        @(posedge sys_clk) en <= 1'b1;
    endtask : t_tally
    task automatic t_stall;
        @(posedge sys_clk) th_data <= 12'h100;
        pulse(2);
        chk(th, 12'h100);
        @(posedge sys_clk) ripple <= 1'b1;
        enable <= 1'b1;
        hc(12'h050, 4);
        chk({flags, oe}, 12'h08d);
        // detection off first so the low tally cannot relatch it
        @(posedge sys_clk) enable <= 1'b0;
        pulse(0);
        chk(flags, 12'h000);
        hc(12'h050, 2);
        chk(flags, 12'h000);
        @(posedge sys_clk) enable <= 1'b1;
        report <= 1'b1;
        hc(12'h050, 1);
        chk({flags.blocked_flag, oe}, 12'h2);
        @(posedge sys_clk) enable <= 1'b0;
        pulse(0);
        chk(oe, 12'h1);
    endtask : t_stall
    task automatic t_learn;
        @(posedge sys_clk) learn <= 1'b1;
        hc(12'h040, 4);
        @(posedge sys_clk) learn <= 1'b0;
        cyc(4);
        chk(th, 12'h050);
        chk(flags.threshold_learn_done, 12'h1);
    endtask : t_learn
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        end_of_test();
    end
    initial begin
        cyc(5);
        chk({flags, oe}, 12'h001);
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        cyc(5);
        chk({flags, oe}, 12'h080);
        @(posedge sys_clk) supply_low_cmp <= 1'b0;
        cyc(5);
        chk({flags, oe, br}, 12'h007);
        t_supply();
        t_pump();
        t_ocp();
        t_tally();
        t_stall();
        t_learn();
        end_of_test();
    end
endmodule : mfsm_monitor_test
`default_nettype wire

/* File: verilog/mfsm_monitor.sv */
// fault supervision and stall detection core
`include "mfsm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module mfsm_monitor
    import mfsm_pkg::*;
#(
    parameter int RETRY_CYC = `MFSM_RETRY_CYC
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire logic                      clk_en,
    // analog comparator pins and the sleep pin
    input  wire logic                      supply_low_cmp,
    input  wire logic                      pump_low_cmp,
    input  wire logic [3:0]                bridge_limit,
    input  wire logic [`MFSM_SHORTS_W-1:0] short_sense,
    input  wire logic                      sleep_pin_n,
    // configuration and commands
    input  wire logic                      overcurrent_recovery_select,
    input  wire logic                      clear_faults_cmd,
    input  wire logic                      ripple_mode,
    input  wire logic                      blocked_detect_enable,
    input  wire logic                      blocked_pin_report,
    input  wire logic                      tally_scale_bit,
    input  wire logic                      threshold_learn_start,
    input  wire logic                      threshold_wr,
    input  wire logic [11:0]               threshold_wdata,
    // half-cycle measurements
    input  wire logic                      half_cycle_done,
    input  wire logic [11:0]               off_time_rise,
    input  wire logic [11:0]               off_time_fall,
    // status
    output mfsm_flags_s                    flags,
    output logic [`MFSM_SHORTS_W-1:0]      short_diag_reg,
    output logic [7:0]                     tally_low_reg,
    output logic [3:0]                     tally_high_reg,
    output logic [11:0]                    blocked_threshold,
    // power stage control
    output logic [1:0]                     bridge_enable,
    output logic                           pump_enable,
    // open-drain fault pin
    output logic                           error_pin_n_out,
    output logic                           error_pin_n_oe
);
    // =========================================================
    // input synchronisers
    // =========================================================
    logic [8:0]  sync1;
    logic [8:0]  sync2;
    logic [`MFSM_SHORTS_W-1:0] short1;
    logic [`MFSM_SHORTS_W-1:0] short2;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sync1  <= 9'h1e0;
            sync2  <= 9'h1e0;
            short1 <= 8'h00;
            short2 <= 8'h00;
        end else if (clk_en) begin
            sync1  <= {sleep_pin_n, 1'b1, 1'b1, supply_low_cmp,
                       pump_low_cmp, bridge_limit};
            sync2  <= sync1;
            short1 <= short_sense;
            short2 <= short1;
        end
    end
    wire logic       sleep_n_s = sync2[8];
    wire logic       uv_s      = sync2[5];
    wire logic       cp_s      = sync2[4];
    wire logic [3:0] lim_s     = sync2[3:0];

    // sleep reset pulse: rising edge of the synchronised sleep pin
    logic sleep_d;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sleep_d <= 1'b1;
        end else if (clk_en) begin
            sleep_d <= sleep_n_s;
        end
    end
    wire logic clr = clear_faults_cmd | (sleep_n_s & ~sleep_d);

    // =========================================================
    // supply and pump flags
    // =========================================================
    // reset models the supply below the reset level: all flags low
    logic uv_flag;
    logic cp_flag;
    wire logic next_uv_flag = uv_s | (uv_flag & ~clr);
    wire logic next_cp_flag = cp_s | (cp_flag & ~clr);
    // power-up indicator: low until supply first rises above threshold
    logic powered;
    // low while the core is held in reset and until the first enabled clock after it
    logic alive;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            uv_flag <= 1'b0;
            cp_flag <= 1'b0;
            powered <= 1'b0;
            alive   <= 1'b0;
        end else if (clk_en) begin
            alive   <= 1'b1;
            // a falling supply after power-up latches the flag
            uv_flag <= powered ? next_uv_flag : 1'b0;
            cp_flag <= next_cp_flag;
            if (!uv_s) begin
                powered <= 1'b1;
            end
        end
    end

    // =========================================================
    // overcurrent per bridge
    // =========================================================
    logic [1:0] oc_flag;
    logic [1:0] oc_hold;
    logic [`MFSM_SHORTS_W-1:0] next_short;
    assign next_short = short2 | (short_diag_reg & {8{~clr}});
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            short_diag_reg <= 8'h00;
        end else if (clk_en) begin
            short_diag_reg <= next_short;
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bridge
            mfsm_oc_e            st;
            logic [`MFSM_CNT_W-1:0] cnt;
            wire logic lim = |lim_s[2*gb+1:2*gb];
            wire logic filt_done =
                (cnt >= `MFSM_CNT_W'(`MFSM_OCP_FILT_CYC));
            wire logic retry_done = (cnt >= `MFSM_CNT_W'(RETRY_CYC));
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    st          <= MFSM_OC_IDLE;
                    cnt         <= '0;
                    oc_flag[gb] <= 1'b0;
                    oc_hold[gb] <= 1'b0;
                end else if (clk_en) begin
                    case (st)
                        MFSM_OC_IDLE: begin
                            oc_flag[gb] <= oc_flag[gb] & ~clr;
                            if (!lim) begin
                                cnt <= '0;
                            end else if (filt_done) begin
                                st          <= MFSM_OC_TRIP;
                                oc_flag[gb] <= 1'b1;
                                oc_hold[gb] <= 1'b1;
                                cnt         <= '0;
                            end else begin
                                cnt <= cnt + 1'b1;
                            end
                        end
                        MFSM_OC_TRIP: begin
                            if (overcurrent_recovery_select) begin
                                st <= MFSM_OC_RETRY;
                            end else if (clr) begin
                                st          <= MFSM_OC_IDLE;
                                oc_hold[gb] <= 1'b0;
                                oc_flag[gb] <= lim;
                            end
                        end
                        MFSM_OC_RETRY: begin
                            if (!retry_done) begin
                                cnt <= cnt + 1'b1;
                            end else if (!lim) begin
                                st          <= MFSM_OC_IDLE;
                                oc_hold[gb] <= 1'b0;
                                cnt         <= '0;
                            end
                        end
                        default: begin
                            st <= MFSM_OC_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // =========================================================
    // torque tally
    // =========================================================
    logic [11:0] hist [`MFSM_AVG_DEPTH];
    wire logic [11:0] diff = (off_time_rise > off_time_fall) ?
        off_time_rise - off_time_fall : `MFSM_ZERO12;
    wire logic [13:0] sum = {2'b00, hist[0]} + {2'b00, hist[1]} +
                            {2'b00, hist[2]} + {2'b00, diff};
    wire logic [11:0] raw = sum[13:`MFSM_AVG_SHIFT];
    wire logic [11:0] scaled =
        (tally_scale_bit && raw < `MFSM_SCALE_LIMIT) ?
        (raw << `MFSM_SCALE_SHIFT) : raw;
    logic [11:0] tally;
    logic        tally_new;
    integer      hi;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (hi = 0; hi < `MFSM_AVG_DEPTH; hi++) begin
                hist[hi] <= `MFSM_ZERO12;
            end
            tally     <= `MFSM_ZERO12;
            tally_new <= 1'b0;
        end else if (clk_en) begin
            tally_new <= half_cycle_done;
            if (half_cycle_done) begin
                hist[0] <= diff;
                for (hi = 1; hi < `MFSM_AVG_DEPTH; hi++) begin
                    hist[hi] <= hist[hi-1];
                end
                tally <= scaled;
            end
        end
    end
    assign tally_low_reg  = tally[7:0];
    assign tally_high_reg = tally[11:8];

    // =========================================================
    // stall detect and threshold learning
    // =========================================================
    wire logic any_fault = uv_s | cp_s | (|oc_hold) | ~powered;
    wire logic detect_on = ripple_mode & blocked_detect_enable &
                           ~any_fault;
    wire logic stall_hit = detect_on & tally_new &
                           (tally < blocked_threshold);
    logic       stl_flag;
    logic       lrn_ok;
    mfsm_lrn_e  lrn_st;
    logic [11:0] lrn_min;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stl_flag          <= 1'b0;
            lrn_ok            <= 1'b0;
            lrn_st            <= MFSM_LRN_IDLE;
            lrn_min           <= 12'hfff;
            blocked_threshold <= `MFSM_ZERO12;
        end else if (clk_en) begin
            stl_flag <= stall_hit | (stl_flag & ~clr);
            if (threshold_wr) begin
                blocked_threshold <= threshold_wdata;
            end
            case (lrn_st)
                MFSM_LRN_IDLE: begin
                    if (threshold_learn_start) begin
                        lrn_st  <= MFSM_LRN_RUN;
                        lrn_ok  <= 1'b0;
                        lrn_min <= 12'hfff;
                    end
                end
                MFSM_LRN_RUN: begin
                    // the deliberate stall shows as a collapsing tally
                    if (tally_new && tally < lrn_min) begin
                        lrn_min <= tally;
                    end
                    if (!threshold_learn_start) begin
                        lrn_st <= MFSM_LRN_DONE;
                    end
                end
                MFSM_LRN_DONE: begin
                    lrn_st <= MFSM_LRN_IDLE;
                    if (lrn_min != 12'hfff) begin
                        blocked_threshold <= lrn_min + `MFSM_LEARN_MARGIN;
                        lrn_ok            <= 1'b1;
                    end
                end
                default: begin
                    lrn_st <= MFSM_LRN_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    // core in reset: pin released and summary flag low
    wire logic pin_fault = alive & (uv_s | cp_s | (|oc_hold) |
                           (stl_flag & blocked_pin_report) |
                           ~powered);
    // raw pump condition too, so the pin never leads the flag
    assign flags.fault = alive & (uv_s | ~powered | cp_s | cp_flag |
                         (|oc_flag) | stl_flag);
    assign flags.supply_low_flag      = uv_flag;
    assign flags.pump_undervolt_flag  = cp_flag;
    assign flags.overcurrent_flag     = |oc_flag;
    assign flags.blocked_flag         = stl_flag;
    assign flags.blocked_detail_flag  = stl_flag;
    assign flags.threshold_learn_done = lrn_ok;
    assign pump_enable   = ~uv_s & powered;
    assign bridge_enable = {2{~uv_s & ~cp_s & powered}} & ~oc_hold;
    assign error_pin_n_out = 1'b0;
    assign error_pin_n_oe  = ~pin_fault;
endmodule : mfsm_monitor
`default_nettype wire
